// ==== design/rsc_pkg.sv ====
// constants and types shared by the run and stop command logic
package rsc_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TERM_FN = 8'h04;
   localparam logic [7:0] ADDR_START_TIMES = 8'h08;
   localparam logic [7:0] ADDR_HOLD_DECEL = 8'h0c;
   localparam logic [7:0] ADDR_HOST_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_MACRO = 8'h18;
   localparam logic [7:0] ADDR_PULSE_CNT = 8'h1c;

   // control register layout: {stop_mode, start_mode, tmode[1:0], src[1:0]}
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   // host command bits
   localparam int HOST_FWD_BIT = 0;
   localparam int HOST_REV_BIT = 1;
   localparam int HOST_STOP_BIT = 2;

   // command_source_select values
   localparam logic [1:0] SRC_KEYPAD = 2'h0;
   localparam logic [1:0] SRC_TERM = 2'h1;
   localparam logic [1:0] SRC_HOST = 2'h2;

   // terminal_control_mode values
   localparam logic [1:0] TM_RUN_DIR = 2'h0;
   localparam logic [1:0] TM_FWD_REV = 2'h1;
   localparam logic [1:0] TM_3L_FWD_REV = 2'h2;
   localparam logic [1:0] TM_3L_RUN_DIR = 2'h3;

   // input terminal function codes, two bits per input
   localparam logic [1:0] FN_NONE = 2'h0;
   localparam logic [1:0] FN_RUN = 2'h1;
   localparam logic [1:0] FN_DIR = 2'h2;
   localparam logic [1:0] FN_STOP3 = 2'h3;
   // first input run, second direction, third three-line stop
   localparam logic [13:0] TERM_FN_RST = 14'h0039;

   // times in milliseconds
   localparam logic [15:0] DC_TIME_RST = 16'h0000;
   localparam logic [15:0] PRE_TIME_RST = 16'h0000;
   localparam logic [15:0] HOLD_TIME_RST = 16'h0000;
   localparam logic [15:0] DECEL_TIME_RST = 16'h3a98;
   localparam logic [7:0] MACRO_RST = 8'h00;

   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int DEB_MS = 5;
   localparam logic [3:0] DEB_TICKS = 4'(DEB_MS * 1000 / TICK_US);
   localparam int BLINK_MS = 250;
   localparam logic [7:0] BLINK_TICKS = 8'(BLINK_MS * 1000 / TICK_US);
   localparam int PULSE_MAX_HZ = 200_000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DCBRK = 3'b001,
      ST_PREEX = 3'b010,
      ST_HOLD = 3'b011,
      ST_TRACK = 3'b100,
      ST_RUN = 3'b101,
      ST_DECEL = 3'b110
   } rsc_state_t;

endpackage

// ==== design/rsc_run_stop_ctrl.sv ====
// run and stop command logic with ahb-lite register slave
// Contract
// - Source 0: only keypad run and stop keys start and stop.
// - Keypad run key starts only while no trip is active.
// - Run indicator steady while running, flashing while decelerating to stop.
// - Source 1: terminals assigned by function codes, decoded per terminal mode.
// - Source 2: only host commands over the serial port start and stop.
// - Direct start: dc brake, pre-excitation if times nonzero, hold, then run.
// - Start mode 1: track motor speed first, then start from it.
// - Stop mode 0: ramp down over the deceleration time.
// - Stop mode 1: output cut at once, motor coasts.
// - Terminal mode field has four values, default 0.
// - Function code 1 is run terminal, code 2 direction terminal.
// - Mode 0: run level starts and stops, direction level selects reverse.
// - Mode 1: run forward, direction reverse, both active stops.
// - Mode 2: edges start forward or reverse, opened stop terminal stops.
// - Three-line stop terminal is whichever input holds code 3.
// - Seventh input also counts pulses up to 200 kHz.
// - Mode 3: run edge starts, direction level, stop terminal level stops.
// - Writing the macro selection reloads default settings.
// - After power-on display shows zero frequency.
// - Active protection shows its code on the display.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module rsc_run_stop_ctrl
   import rsc_pkg::*;
#(
   parameter int TICK_CYC_P = TICK_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic run_key_i,
   input wire logic stop_key_i,
   input wire logic [6:0] term_i,
   input wire logic trip_i,
   input wire logic [7:0] trip_code_i,
   input wire logic track_done_i,
   output logic out_enable_o,
   output logic dir_rev_o,
   output logic dc_brake_o,
   output logic pre_excite_o,
   output logic hold_o,
   output logic track_o,
   output logic decel_o,
   output logic run_led_o,
   output logic disp_protect_o,
   output logic [7:0] disp_code_o,
   output logic disp_zero_o
);

   localparam int NIN = 9;
   localparam int KEY_RUN = 7;
   localparam int KEY_STOP = 8;
   localparam int PULSE_IN = 6;

   if (TICK_CYC_P < 2 || TICK_CYC_P > 65536) begin : g_chk_tick
      $error("TICK_CYC_P out of range 2..65536");
   end
   if (CLK_HZ < 4 * PULSE_MAX_HZ) begin : g_chk_pulse
      $error("clock too slow for the pulse input");
   end

   typedef struct packed {
      logic [NIN-1:0] sync1;
      logic [NIN-1:0] sync2;
      logic [NIN-1:0] deb;
      logic [NIN-1:0] deb_q;
      logic [NIN-1:0][3:0] deb_cnt;
      logic pulse_q;
      logic [15:0] pulse_cnt;
      logic stop_mode;
      logic start_mode;
      logic [1:0] tmode;
      logic [1:0] src;
      logic [13:0] term_fn;
      logic [15:0] dc_time;
      logic [15:0] pre_time;
      logic [15:0] hold_time;
      logic [15:0] decel_time;
      logic [7:0] macro;
      logic host_fwd;
      logic host_rev;
      logic host_stop;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] rdata;
      rsc_state_t state;
      logic dir;
      logic [15:0] tmr;
      logic [15:0] tick_cnt;
      logic tick;
      logic [7:0] blink_cnt;
      logic blink;
   } rsc_regs_t;

   rsc_regs_t r_reg;
   rsc_regs_t r_next;

   logic run_t;
   logic dir_t;
   logic run_p;
   logic dir_p;
   logic stop_t;
   logic has_stop;
   logic stop_act;
   logic run_rise;
   logic dir_rise;
   logic go;
   logic go_dir;
   logic halt;
   logic ap;
   logic [31:0] rd_mux;
   logic [1:0] fn;

   always_comb begin
      r_next = r_reg;
      run_t = 1'b0;
      dir_t = 1'b0;
      run_p = 1'b0;
      dir_p = 1'b0;
      stop_t = 1'b0;
      has_stop = 1'b0;
      go = 1'b0;
      go_dir = r_reg.dir;
      halt = 1'b0;
      fn = FN_NONE;
      rd_mux = 32'h0000_0000;
      r_next.host_fwd = 1'b0;
      r_next.host_rev = 1'b0;
      r_next.host_stop = 1'b0;

      // millisecond tick enable
      r_next.tick = 1'b0;
      if (r_reg.tick_cnt == 16'(TICK_CYC_P - 1)) begin
         r_next.tick_cnt = 16'h0000;
         r_next.tick = 1'b1;
      end else begin
         r_next.tick_cnt = r_reg.tick_cnt + 16'h0001;
      end

      r_next.sync1 = {stop_key_i, run_key_i, term_i};
      r_next.sync2 = r_reg.sync1;
      for (int i = 0; i < NIN; i++) begin
         if (r_reg.sync2[i] == r_reg.deb[i]) begin
            r_next.deb_cnt[i] = 4'h0;
         end else if (r_reg.tick) begin
            if (r_reg.deb_cnt[i] == DEB_TICKS - 4'h1) begin
               r_next.deb[i] = r_reg.sync2[i];
               r_next.deb_cnt[i] = 4'h0;
            end else begin
               r_next.deb_cnt[i] = r_reg.deb_cnt[i] + 4'h1;
            end
         end
      end
      r_next.deb_q = r_reg.deb;

      // raw edge count, the debounce would swallow fast pulses
      r_next.pulse_q = r_reg.sync2[PULSE_IN];
      if (r_reg.sync2[PULSE_IN] && !r_reg.pulse_q) begin
         r_next.pulse_cnt = r_reg.pulse_cnt + 16'h0001;
      end

      for (int i = 0; i < 7; i++) begin
         fn = r_reg.term_fn[2*i +: 2];
         if (fn == FN_RUN) begin
            run_t = run_t | r_reg.deb[i];
            run_p = run_p | r_reg.deb_q[i];
         end
         if (fn == FN_DIR) begin
            dir_t = dir_t | r_reg.deb[i];
            dir_p = dir_p | r_reg.deb_q[i];
         end
         if (fn == FN_STOP3) begin
            stop_t = stop_t | r_reg.deb[i];
            has_stop = 1'b1;
         end
      end
      run_rise = run_t & ~run_p;
      dir_rise = dir_t & ~dir_p;
      // normally closed: opening the contact means stop
      stop_act = has_stop & ~stop_t;

      unique case (r_reg.src)
         SRC_KEYPAD: begin
            go = r_reg.deb[KEY_RUN] & ~r_reg.deb_q[KEY_RUN];
            halt = r_reg.deb[KEY_STOP] & ~r_reg.deb_q[KEY_STOP];
         end
         SRC_TERM: begin
            unique case (r_reg.tmode)
               TM_RUN_DIR: begin
                  go = run_t;
                  halt = ~run_t;
                  go_dir = dir_t;
               end
               TM_FWD_REV: begin
                  go = run_t ^ dir_t;
                  halt = ~(run_t ^ dir_t);
                  go_dir = dir_t;
               end
               TM_3L_FWD_REV: begin
                  halt = stop_act;
                  go = ~stop_act & (run_rise | dir_rise);
                  go_dir = dir_rise & ~run_rise;
               end
               TM_3L_RUN_DIR: begin
                  halt = stop_act;
                  go = ~stop_act & run_rise;
                  go_dir = dir_t;
               end
            endcase
         end
         SRC_HOST: begin
            go = r_reg.host_fwd | r_reg.host_rev;
            go_dir = r_reg.host_rev;
            halt = r_reg.host_stop;
         end
         default: begin
            halt = 1'b1;
         end
      endcase

      // phase timer counts down in milliseconds
      if (r_reg.tick && r_reg.tmr != 16'h0000) begin
         r_next.tmr = r_reg.tmr - 16'h0001;
      end

      unique case (r_reg.state)
         ST_IDLE: begin
            if (go && !halt && !trip_i) begin
               r_next.dir = go_dir;
               if (r_reg.start_mode) begin
                  r_next.state = ST_TRACK;
               end else if (r_reg.dc_time != 16'h0000) begin
                  r_next.state = ST_DCBRK;
                  r_next.tmr = r_reg.dc_time;
               end else if (r_reg.pre_time != 16'h0000) begin
                  r_next.state = ST_PREEX;
                  r_next.tmr = r_reg.pre_time;
               end else begin
                  r_next.state = ST_HOLD;
                  r_next.tmr = r_reg.hold_time;
               end
            end
         end
         ST_DCBRK: begin
            if (r_reg.tmr == 16'h0000) begin
               if (r_reg.pre_time != 16'h0000) begin
                  r_next.state = ST_PREEX;
                  r_next.tmr = r_reg.pre_time;
               end else begin
                  r_next.state = ST_HOLD;
                  r_next.tmr = r_reg.hold_time;
               end
            end
         end
         ST_PREEX: begin
            if (r_reg.tmr == 16'h0000) begin
               r_next.state = ST_HOLD;
               r_next.tmr = r_reg.hold_time;
            end
         end
         ST_HOLD: begin
            // starting frequency held, then set frequency
            if (r_reg.tmr == 16'h0000) begin
               r_next.state = ST_RUN;
            end
         end
         ST_TRACK: begin
            if (track_done_i) begin
               r_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (go && !halt) begin
               r_next.dir = go_dir;
            end
         end
         ST_DECEL: begin
            if (go && !halt) begin
               r_next.state = ST_RUN;
               r_next.dir = go_dir;
            end else if (r_reg.tmr == 16'h0000) begin
               r_next.state = ST_IDLE;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase

      // stop request from any active phase except deceleration
      if (halt && r_reg.state != ST_IDLE && r_reg.state != ST_DECEL) begin
         if (r_reg.stop_mode) begin
            r_next.state = ST_IDLE;
         end else begin
            r_next.state = ST_DECEL;
            r_next.tmr = r_reg.decel_time;
         end
      end
      // protection overrides everything and coasts
      if (trip_i) begin
         r_next.state = ST_IDLE;
      end

      if (r_reg.tick) begin
         if (r_reg.blink_cnt == BLINK_TICKS - 8'h01) begin
            r_next.blink_cnt = 8'h00;
            r_next.blink = ~r_reg.blink;
         end else begin
            r_next.blink_cnt = r_reg.blink_cnt + 8'h01;
         end
      end

      // bus address phase; master is non-pipelined so no overlap
      ap = hsel_i & htrans_i[1] & hready_i;
      r_next.ap_valid = ap & (haddr_i[31:8] == 24'h000000);
      r_next.ap_write = hwrite_i;
      r_next.ap_addr = haddr_i[7:0];
      if (haddr_i[31:8] == 24'h000000) begin
         case (haddr_i[7:0])
            ADDR_CTRL: rd_mux = {26'h0, r_reg.stop_mode, r_reg.start_mode,
                                 r_reg.tmode, r_reg.src};
            ADDR_TERM_FN: rd_mux = {18'h0, r_reg.term_fn};
            ADDR_START_TIMES: rd_mux = {r_reg.pre_time, r_reg.dc_time};
            ADDR_HOLD_DECEL: rd_mux = {r_reg.decel_time, r_reg.hold_time};
            ADDR_STATUS: rd_mux = {7'h0, r_reg.deb, disp_code_o, 2'h0,
                                   trip_i, run_led_o, r_reg.dir,
                                   r_reg.state};
            ADDR_MACRO: rd_mux = {24'h0, r_reg.macro};
            ADDR_PULSE_CNT: rd_mux = {16'h0, r_reg.pulse_cnt};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
      if (ap && !hwrite_i) begin
         r_next.rdata = rd_mux;
      end

      // bus data phase writes
      if (r_reg.ap_valid && r_reg.ap_write) begin
         case (r_reg.ap_addr)
            ADDR_CTRL: begin
               // four mode values in two bits
               {r_next.stop_mode, r_next.start_mode, r_next.tmode,
                r_next.src} = hwdata_i[CTRL_W-1:0];
            end
            ADDR_TERM_FN: r_next.term_fn = hwdata_i[13:0];
            ADDR_START_TIMES: begin
               r_next.dc_time = hwdata_i[15:0];
               r_next.pre_time = hwdata_i[31:16];
            end
            ADDR_HOLD_DECEL: begin
               r_next.hold_time = hwdata_i[15:0];
               r_next.decel_time = hwdata_i[31:16];
            end
            ADDR_HOST_CMD: begin
               r_next.host_fwd = hwdata_i[HOST_FWD_BIT];
               r_next.host_rev = hwdata_i[HOST_REV_BIT];
               r_next.host_stop = hwdata_i[HOST_STOP_BIT];
            end
            ADDR_MACRO: begin
               r_next.macro = hwdata_i[7:0];
               {r_next.stop_mode, r_next.start_mode, r_next.tmode,
                r_next.src} = CTRL_RST;
               r_next.term_fn = TERM_FN_RST;
               r_next.dc_time = DC_TIME_RST;
               r_next.pre_time = PRE_TIME_RST;
               r_next.hold_time = HOLD_TIME_RST;
               r_next.decel_time = DECEL_TIME_RST;
            end
            ADDR_PULSE_CNT: r_next.pulse_cnt = 16'h0000;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_reg <= '0;
         {r_reg.stop_mode, r_reg.start_mode, r_reg.tmode, r_reg.src} <=
            CTRL_RST;
         r_reg.term_fn <= TERM_FN_RST;
         r_reg.dc_time <= DC_TIME_RST;
         r_reg.pre_time <= PRE_TIME_RST;
         r_reg.hold_time <= HOLD_TIME_RST;
         r_reg.decel_time <= DECEL_TIME_RST;
         r_reg.macro <= MACRO_RST;
         r_reg.state <= ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // zero-wait slave, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = r_reg.rdata;

   assign out_enable_o = (r_reg.state != ST_IDLE);
   assign dir_rev_o = r_reg.dir;
   assign dc_brake_o = (r_reg.state == ST_DCBRK);
   assign pre_excite_o = (r_reg.state == ST_PREEX);
   assign hold_o = (r_reg.state == ST_HOLD);
   assign track_o = (r_reg.state == ST_TRACK);
   assign decel_o = (r_reg.state == ST_DECEL);
   assign run_led_o = (r_reg.state == ST_DECEL) ? r_reg.blink :
                      (r_reg.state != ST_IDLE);
   assign disp_protect_o = trip_i;
   assign disp_code_o = trip_i ? trip_code_i : 8'h00;
   // stopped output reads as zero frequency
   assign disp_zero_o = (r_reg.state == ST_IDLE);

endmodule

`default_nettype wire

// ==== bench/rsc_far_side.sv ====
// speed sensing partner that answers the tracking phase
`timescale 1ns/100ps
`default_nettype none
module rsc_far_side (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic track_i,
   input wire logic slow_i,
   output logic done_o
);
   logic [5:0] cnt;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= 6'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= track_i && (cnt == (slow_i ? 6'h1e : 6'h02));
         cnt <= track_i ? cnt + 6'h1 : 6'h0;
      end
   end
endmodule
`default_nettype wire

// ==== bench/rsc_props_properties.sv ====
// port assertions for the run and stop command logic
`timescale 1ns/100ps
`default_nettype none
module rsc_props (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic trip_i,
   input wire logic [7:0] trip_code_i,
   input wire logic track_done_i,
   input wire logic out_enable_o,
   input wire logic dc_brake_o,
   input wire logic pre_excite_o,
   input wire logic hold_o,
   input wire logic track_o,
   input wire logic decel_o,
   input wire logic run_led_o,
   input wire logic disp_protect_o,
   input wire logic [7:0] disp_code_o,
   input wire logic disp_zero_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   bus_okay_a: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not okay");
   protect_code_a: assert property (disp_protect_o == trip_i &&
      disp_code_o == (trip_i ? trip_code_i : 8'h00))
      else $error("protection display wrong");
   zero_shown_a: assert property (disp_zero_o == !out_enable_o)
      else $error("zero display wrong");
   trip_stops_a: assert property (trip_i |=> !out_enable_o)
      else $error("output on during trip");
   led_steady_a: assert property (out_enable_o && !decel_o &&
      $past(out_enable_o) && !$past(decel_o) |-> run_led_o)
      else $error("run indicator not steady");
   led_dark_a: assert property (!out_enable_o &&
      !$past(out_enable_o) |-> !run_led_o)
      else $error("run indicator lit while stopped");
   one_phase_a: assert property (|{dc_brake_o, pre_excite_o, hold_o,
      track_o, decel_o} |-> out_enable_o &&
      $onehot0({dc_brake_o, pre_excite_o, hold_o, track_o, decel_o}))
      else $error("phase indicators inconsistent");
   track_end_a: assert property (track_o && track_done_i &&
      !trip_i |=> !track_o)
      else $error("tracking did not end");
   brake_next_a: assert property ($fell(dc_brake_o) && out_enable_o
      |-> pre_excite_o || hold_o || decel_o)
      else $error("wrong phase after dc brake");
   excite_next_a: assert property ($fell(pre_excite_o) &&
      out_enable_o |-> hold_o || decel_o)
      else $error("wrong phase after pre-excitation");
endmodule
bind rsc_run_stop_ctrl rsc_props props_u (.clk_i(clk_i),
   .arst_n_i(arst_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .trip_i(trip_i), .trip_code_i(trip_code_i), .track_done_i(track_done_i),
   .out_enable_o(out_enable_o), .dc_brake_o(dc_brake_o),
   .pre_excite_o(pre_excite_o), .hold_o(hold_o), .track_o(track_o),
   .decel_o(decel_o), .run_led_o(run_led_o),
   .disp_protect_o(disp_protect_o), .disp_code_o(disp_code_o),
   .disp_zero_o(disp_zero_o));
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the run and stop command logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rsc_pkg::*;
   // short tick so ms times and debounce stay a few cycles
   localparam int TK = 4;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [8:0] pins = 9'h0;
   logic trip = 1'b0;
   logic [7:0] tcode = 8'h00;
   logic slow = 1'b1;
   logic hready, hresp, tdone, out_en, dir_rev, dc, pre, hold, track;
   logic decel, led, dprot, dzero, led_last;
   logic [7:0] dcode;
   logic [31:0] hrdata, rd;
   logic [4:0] ph_q [$];
   logic [4:0] ph_last = 5'h0;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int flips;
   always #10 clk_i = ~clk_i;
   rsc_run_stop_ctrl #(.TICK_CYC_P(TK)) dut_u (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
      .hresp_o(hresp), .hrdata_o(hrdata), .run_key_i(pins[7]),
      .stop_key_i(pins[8]), .term_i(pins[6:0]), .trip_i(trip),
      .trip_code_i(tcode), .track_done_i(tdone), .out_enable_o(out_en),
      .dir_rev_o(dir_rev), .dc_brake_o(dc), .pre_excite_o(pre),
      .hold_o(hold), .track_o(track), .decel_o(decel), .run_led_o(led),
      .disp_protect_o(dprot), .disp_code_o(dcode), .disp_zero_o(dzero));
   rsc_far_side far_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .track_i(track), .slow_i(slow), .done_o(tdone));
   always @(posedge clk_i) begin
      if ({decel, track, hold, pre, dc} !== ph_last)
         ph_q.push_back({decel, track, hold, pre, dc});
      ph_last <= {decel, track, hold, pre, dc};
   end
   task close_out;
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         close_out;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_i); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, rd);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, rd);
      chk(rd, e);
   endtask
   task st(input logic [2:0] e);
      int n;
      n = 0;
      do begin
         xfer(1'b0, ADDR_STATUS, 32'h0, rd);
         n++;
      end while (rd[2:0] !== e && n < 1000);
      chk({29'h0, rd[2:0]}, {29'h0, e});
   endtask
   // pins held past sync and debounce
   task pin(input int i, input logic v);
      @(posedge clk_i);
      pins[i] <= v;
      repeat (40) @(posedge clk_i);
   endtask
   task tap(input int i);
      pin(i, 1'b1);
      pin(i, 1'b0);
   endtask
   task ph(input logic [4:0] e);
      chk(ph_q.size() > 0 ? {27'h0, ph_q.pop_front()} : 32'hffff, {27'h0, e});
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rdc(ADDR_CTRL, 32'h0);
      rdc(ADDR_TERM_FN, 32'h39);
      rdc(ADDR_HOLD_DECEL, 32'h3a980000);
      rdc(8'h20, 32'h0);
      chk({31'h0, dzero}, 32'h1);
      wr(ADDR_CTRL, 32'h20);
      pin(0, 1'b1);
      st(3'h0);
      pin(0, 1'b0);
      trip <= 1'b1;
      tap(7);
      st(3'h0);
      trip <= 1'b0;
      tap(7);
      st(3'h5);
      tap(8);
      st(3'h0);
      wr(ADDR_CTRL, 32'h00);
      wr(ADDR_START_TIMES, 32'h00020002);
      wr(ADDR_HOLD_DECEL, 32'h02580002);
      ph_q.delete();
      tap(7);
      st(3'h5);
      tap(8);
      st(3'h6);
      flips = 0;
      led_last = led;
      repeat (1100) begin
         @(negedge clk_i);
         if (led !== led_last)
            flips++;
         led_last = led;
      end
      chk({31'h0, flips > 0}, 32'h1);
      st(3'h0);
      ph(5'h01);
      ph(5'h02);
      ph(5'h04);
      ph(5'h00);
      ph(5'h10);
      ph(5'h00);
      wr(ADDR_CTRL, 32'h30);
      ph_q.delete();
      tap(7);
      st(3'h5);
      ph(5'h08);
      ph(5'h00);
      tap(8);
      wr(ADDR_CTRL, 32'h21);
      pin(0, 1'b1);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h0);
      pin(1, 1'b1);
      chk({31'h0, dir_rev}, 32'h1);
      pin(0, 1'b0);
      st(3'h0);
      pin(1, 1'b0);
      wr(ADDR_CTRL, 32'h25);
      pin(0, 1'b1);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h0);
      pin(1, 1'b1);
      st(3'h0);
      pin(0, 1'b0);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h1);
      pin(1, 1'b0);
      st(3'h0);
      wr(ADDR_CTRL, 32'h29);
      pin(2, 1'b1);
      tap(0);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h0);
      pin(2, 1'b0);
      st(3'h0);
      tap(1);
      st(3'h0);
      pin(2, 1'b1);
      tap(1);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h1);
      pin(2, 1'b0);
      wr(ADDR_CTRL, 32'h2d);
      wr(ADDR_TERM_FN, 32'h309);
      pin(4, 1'b1);
      pin(1, 1'b1);
      tap(0);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h1);
      pin(4, 1'b0);
      st(3'h0);
      pin(1, 1'b0);
      wr(ADDR_CTRL, 32'h22);
      pin(0, 1'b1);
      st(3'h0);
      pin(0, 1'b0);
      wr(ADDR_HOST_CMD, 32'h2);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h1);
      wr(ADDR_HOST_CMD, 32'h4);
      st(3'h0);
      wr(ADDR_HOST_CMD, 32'h1);
      st(3'h5);
      chk({31'h0, dir_rev}, 32'h0);
      trip <= 1'b1;
      tcode <= 8'h5a;
      repeat (3) @(posedge clk_i);
      chk({31'h0, out_en}, 32'h0);
      chk({24'h0, dcode}, 32'h5a);
      chk({31'h0, dprot}, 32'h1);
      trip <= 1'b0;
      // source 3 is a standing stop, host pulses ignored
      wr(ADDR_CTRL, 32'h23);
      wr(ADDR_HOST_CMD, 32'h1);
      st(3'h0);
      wr(ADDR_PULSE_CNT, 32'h0);
      // within the 200 kHz limit
      repeat (5) begin
         @(posedge clk_i);
         pins[6] <= 1'b1;
         repeat (125) @(posedge clk_i);
         pins[6] <= 1'b0;
         repeat (125) @(posedge clk_i);
      end
      rdc(ADDR_PULSE_CNT, 32'h5);
      wr(ADDR_MACRO, 32'h1);
      rdc(ADDR_CTRL, 32'h0);
      rdc(ADDR_TERM_FN, 32'h39);
      rdc(ADDR_START_TIMES, 32'h0);
      close_out;
   end
endmodule
`default_nettype wire
